// ==== fcsd_pkg.sv ====
// Constants and types shared by the flash command decoder and its host end.
package fcsd_pkg;
  localparam int ADDR_W = 16;
  localparam int DEC_W = 12;
  localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
  localparam logic [11:0] ADDR_UNLOCK2 = 12'hAAA;
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_SECTOR = 8'h30;
  localparam logic [7:0] CMD_BULK = 8'h10;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_BYP_EXIT = 8'h00;
  localparam logic [7:0] PROT_YES = 8'h01;
  localparam logic [7:0] PROT_NO = 8'h00;
  localparam logic [2:0] QRY_IDENT = 3'h1;
  localparam logic [2:0] QRY_PROT = 3'h2;
  localparam int CLK_MHZ = 50;
  localparam int ERASE_WIN_US = 80;
  localparam int ERASE_WIN_CYC = ERASE_WIN_US * CLK_MHZ;
  localparam int TIMEOUT_CYC_DEF = 1000;
  localparam int OP_CYC_DEF = 64;
  typedef enum logic [1:0] {
    FCSD_CMD_NONE = 2'h0,
    FCSD_CMD_PROG = 2'h1,
    FCSD_CMD_SERASE = 2'h2,
    FCSD_CMD_BERASE = 2'h3
  } fcsd_cmd_t;
endpackage : fcsd_pkg

// ==== fcsd_bus_if.sv ====
// Parallel flash bus between host controller and decoder.
`timescale 1ns/1ns
`default_nettype none
interface fcsd_bus_if;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic write_strobe_pin_n;
  logic rd_n;
  logic [7:0] primary_sector_selects;
  logic [3:0] secondary_sector_selects;
  logic busy_indicator_pin;
  modport device (
    input addr, wdata, write_strobe_pin_n, rd_n,
    input primary_sector_selects, secondary_sector_selects,
    output rdata, busy_indicator_pin
  );
  modport host (
    output addr, wdata, write_strobe_pin_n, rd_n,
    output primary_sector_selects, secondary_sector_selects,
    input rdata, busy_indicator_pin
  );
endinterface : fcsd_bus_if
`default_nettype wire

// ==== fcsd_sync.sv ====
// Two-flop synchroniser for pin inputs, one per bit.
`timescale 1ns/1ns
`default_nettype none
module fcsd_sync #(
  parameter int W = 1
) (
  // Clock, reset, enable.
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Data.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r <= '0;
      s2_r <= '0;
    end else if (clk_en) begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end
  assign q = s2_r;
endmodule : fcsd_sync
`default_nettype wire

// ==== fcsd_device.sv ====
// Flash command sequence decoder, device end.
`timescale 1ns/1ns
`default_nettype none
module fcsd_device #(
  parameter int TIMEOUT_CYC = fcsd_pkg::TIMEOUT_CYC_DEF,
  parameter int OP_CYC = fcsd_pkg::OP_CYC_DEF,
  parameter logic [7:0] IDENT_CODE = 8'h5A
) (
  // Clock, reset, enable.
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Flash bus.
  fcsd_bus_if.device bus,
  // Array side.
  input wire logic [7:0] array_rdata,
  input wire logic [7:0] prim_protect,
  input wire logic [3:0] sec_protect,
  output logic exec_valid,
  output logic [1:0] exec_cmd,
  output logic exec_secondary,
  output logic [15:0] exec_addr,
  output logic [7:0] exec_data,
  output logic [11:0] exec_sectors,
  output logic error_status_bit
);
  import fcsd_pkg::*;
  if (TIMEOUT_CYC < 2 || OP_CYC < 2) begin : g_bad_counts
    $error("fcsd_device: counts too small");
  end
  // IDENT_CODE default is arbitrary.

  typedef enum logic [10:0] {
    S_READ = 11'h001, S_U1 = 11'h002, S_U2 = 11'h004, S_E1 = 11'h008,
    S_E2 = 11'h010, S_E3 = 11'h020, S_PROG = 11'h040, S_QUERY = 11'h080,
    S_BYP = 11'h100, S_BPROG = 11'h200, S_BEXIT = 11'h400
  } fcsd_state_t;

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] a_s;
  logic [7:0] d_s;
  logic wr_s;
  logic rd_s;
  logic [11:0] sel_s;
  fcsd_sync #(.W(38)) u_sync (
    .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
    .d({bus.addr, bus.wdata, ~bus.write_strobe_pin_n, ~bus.rd_n,
        bus.secondary_sector_selects, bus.primary_sector_selects}),
    .q({a_s, d_s, wr_s, rd_s, sel_s})
  );

  fcsd_state_t st_r, st_nxt;
  logic wr_d_r;
  logic [15:0] wa_r;
  logic byp_r, susp_r, sec_act_r, bulk_r, qsec_r;
  logic [31:0] to_r, op_r, win_r;
  logic [7:0] pdata_r;
  logic [11:0] esel_r;

  // Strobes cross inverted so the synchroniser's reset level reads as idle
  // and no false strobe edge follows reset.
  wire wr_n_s = !wr_s;
  wire rd_n_s = !rd_s;
  wire wr_fall = wr_d_r && !wr_n_s;
  wire wr_rise = !wr_d_r && wr_n_s;
  wire [11:0] la = wa_r[11:0];
  wire prim_any = |sel_s[7:0];
  wire sec_any = |sel_s[11:8];
  wire flash_sel = prim_any || sec_any;
  wire even_a = !wa_r[0];
  wire busy = op_r != 0;
  wire is_u1 = d_s == CMD_UNLOCK1 && la == ADDR_UNLOCK1;
  wire is_u2 = d_s == CMD_UNLOCK2 && la == ADDR_UNLOCK2;
  wire at555 = la == ADDR_UNLOCK1;
  wire wr_ev = wr_rise && flash_sel;
  wire timed_out = to_r == 1 && st_r != S_READ && st_r != S_BYP;
  wire [11:0] prot_vec = {sec_protect, prim_protect};
  wire sel_prot = |(prot_vec & sel_s);
  wire in_win = win_r != 0;
  wire [2:0] qry_sel = {a_s[6], a_s[1:0]};

  ////////////////////////////////////////////////////////////////////////////
  logic fire;
  fcsd_cmd_t fcmd;
  always_comb begin
    st_nxt = st_r;
    fire = 1'b0;
    fcmd = FCSD_CMD_NONE;
    if (timed_out) begin
      st_nxt = byp_r ? S_BYP : S_READ;
    end else if (wr_ev) begin
      st_nxt = byp_r ? S_BYP : S_READ;
      case (st_r)
        S_READ, S_QUERY: begin
          if (is_u1) st_nxt = S_U1;
          else if (d_s == CMD_SECTOR && in_win && sec_act_r && !susp_r) begin
            fire = 1'b1;
            fcmd = FCSD_CMD_SERASE;
          end
        end
        S_U1: if (is_u2) st_nxt = S_U2;
        S_U2: begin
          if (at555 && d_s == CMD_IDENT) st_nxt = S_QUERY;
          else if (at555 && d_s == CMD_PROGRAM) st_nxt = S_PROG;
          else if (at555 && d_s == CMD_ERASE && !susp_r) st_nxt = S_E1;
          else if (at555 && d_s == CMD_BYPASS) st_nxt = S_BYP;
        end
        S_E1: if (is_u1) st_nxt = S_E2;
        S_E2: if (is_u2) st_nxt = S_E3;
        S_E3: begin
          if (d_s == CMD_SECTOR) begin
            fire = 1'b1;
            fcmd = FCSD_CMD_SERASE;
          end else if (d_s == CMD_BULK && at555) begin
            fire = 1'b1;
            fcmd = FCSD_CMD_BERASE;
          end
        end
        S_PROG, S_BPROG: begin
          fire = 1'b1;
          fcmd = FCSD_CMD_PROG;
        end
        S_BYP: begin
          if (d_s == CMD_PROGRAM && even_a) st_nxt = S_BPROG;
          else if (d_s == CMD_IDENT && even_a) st_nxt = S_BEXIT;
        end
        S_BEXIT: begin
          if (d_s == CMD_BYP_EXIT && even_a) st_nxt = S_READ;
        end
        default: st_nxt = S_READ;
      endcase
      if (st_r != S_BEXIT && st_r != S_PROG && st_r != S_BPROG && even_a) begin
        if (d_s == CMD_RESET) st_nxt = byp_r ? S_BYP : S_READ;
      end
    end
  end

  // Program in a suspended sector or a protected sector is dropped.
  wire prog_ok = !(susp_r && |(esel_r & sel_s)) && !sel_prot;
  // An appended sector joins the running erase instead of waiting for it.
  wire grow = fcmd == FCSD_CMD_SERASE && sec_act_r;
  wire go = fire && (!busy || grow)
            && (fcmd != FCSD_CMD_PROG || prog_ok);
  wire do_susp = wr_ev && st_r == S_READ && d_s == CMD_SUSPEND && even_a
                 && busy && sec_act_r;
  wire do_res = wr_ev && st_r == S_READ && d_s == CMD_SECTOR && even_a
                && susp_r;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= S_READ;
      wr_d_r <= 1'b1;
      wa_r <= '0;
      byp_r <= 1'b0;
      to_r <= '0;
    end else if (clk_en) begin
      wr_d_r <= wr_n_s;
      if (wr_fall) wa_r <= a_s;
      st_r <= st_nxt;
      if (st_nxt == S_BYP) byp_r <= 1'b1;
      else if (st_nxt == S_READ) byp_r <= 1'b0;
      if (wr_ev) to_r <= 32'(TIMEOUT_CYC);
      else if (to_r != 0) to_r <= to_r - 32'd1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      op_r <= '0;
      win_r <= '0;
      susp_r <= 1'b0;
      sec_act_r <= 1'b0;
      bulk_r <= 1'b0;
      esel_r <= '0;
      pdata_r <= 8'hFF;
      error_status_bit <= 1'b0;
    end else if (clk_en) begin
      if (go) begin
        op_r <= 32'(OP_CYC);
        pdata_r <= (fcmd == FCSD_CMD_PROG) ? d_s : 8'hFF;
        sec_act_r <= fcmd == FCSD_CMD_SERASE;
        bulk_r <= fcmd == FCSD_CMD_BERASE;
        esel_r <= (fcmd == FCSD_CMD_SERASE) ? (esel_r | sel_s) : '0;
        if (fcmd == FCSD_CMD_SERASE) win_r <= 32'(ERASE_WIN_CYC);
      end else if (do_susp) begin
        susp_r <= 1'b1;
      end else if (do_res) begin
        susp_r <= 1'b0;
      end else if (!susp_r && op_r != 0) begin
        op_r <= op_r - 32'd1;
      end
      if (!go && win_r != 0) win_r <= win_r - 32'd1;
      if (op_r == 32'd1 && !susp_r) sec_act_r <= 1'b0;
      if (fire && !go) error_status_bit <= 1'b1;
      else if (wr_ev && d_s == CMD_RESET) error_status_bit <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bus.rdata <= '0;
      bus.busy_indicator_pin <= 1'b1;
      exec_valid <= 1'b0;
      exec_cmd <= '0;
      exec_secondary <= 1'b0;
      exec_addr <= '0;
      exec_data <= '0;
      exec_sectors <= '0;
    end else if (clk_en) begin
      bus.busy_indicator_pin <= !(busy && !susp_r);
      exec_valid <= go;
      if (go) begin
        exec_cmd <= fcmd;
        exec_secondary <= !prim_any;
        exec_addr <= wa_r;
        exec_data <= d_s;
        exec_sectors <= sel_s;
      end
      if (!rd_n_s && flash_sel) begin
        if (st_r == S_QUERY && qry_sel == QRY_IDENT && prim_any)
          bus.rdata <= IDENT_CODE;
        else if (st_r == S_QUERY && qry_sel == QRY_PROT)
          bus.rdata <= sel_prot ? PROT_YES : PROT_NO;
        else if (busy && !susp_r)
          bus.rdata <= {~pdata_r[7], 1'b0, error_status_bit, 5'h00};
        else
          bus.rdata <= array_rdata;
      end
    end
  end
  // Query reads decode the read address itself, so no write is needed to
  // pick between identifier and protection.
endmodule : fcsd_device
`default_nettype wire

// ==== fcsd_host.sv ====
// Host end: issues command sequences on the flash bus.
`timescale 1ns/1ns
`default_nettype none
module fcsd_host (
  // Clock, reset, enable.
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // User request.
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [3:0] req_len,
  input wire logic [7:0] req_data [0:6],
  input wire logic [15:0] req_addr [0:6],
  input wire logic req_rd_last,
  input wire logic req_secondary,
  input wire logic [2:0] req_sector,
  output logic [7:0] rsp_data,
  output logic rsp_valid,
  output logic busy_seen,
  // Flash bus.
  fcsd_bus_if.host bus
);
  import fcsd_pkg::*;
  // Each bus cycle takes four phases so the device sees stable levels.
  logic [3:0] idx_r;
  logic [1:0] ph_r;
  logic act_r;
  // A read runs two rounds so its data has crossed the device's input
  // synchroniser and output register before it is taken.
  logic rx_r;
  logic [7:0] rb1_r, rb2_r;
  wire last = idx_r == req_len - 4'd1;
  wire rd_cyc = last && req_rd_last;
  assign req_ready = !act_r;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      act_r <= 1'b0;
      idx_r <= '0;
      ph_r <= '0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      rb1_r <= '0;
      rb2_r <= '0;
      rx_r <= 1'b0;
    end else if (clk_en) begin
      rb1_r <= bus.rdata;
      rb2_r <= rb1_r;
      rsp_valid <= 1'b0;
      if (!act_r && req_valid && req_len != 0) begin
        act_r <= 1'b1;
        rx_r <= 1'b0;
        idx_r <= '0;
        ph_r <= '0;
      end else if (act_r) begin
        ph_r <= ph_r + 2'd1;
        if (ph_r == 2'd3 && rd_cyc && !rx_r) begin
          rx_r <= 1'b1;
        end else if (ph_r == 2'd3) begin
          rx_r <= 1'b0;
          if (rd_cyc) begin
            rsp_data <= rb2_r;
            rsp_valid <= 1'b1;
          end
          if (last) act_r <= 1'b0;
          else idx_r <= idx_r + 4'd1;
        end
      end
    end
  end
  logic [15:0] ao;
  always_comb begin
    ao = req_addr[idx_r[2:0]];
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bus.addr <= '0;
      bus.wdata <= '0;
      bus.write_strobe_pin_n <= 1'b1;
      bus.rd_n <= 1'b1;
      bus.primary_sector_selects <= '0;
      bus.secondary_sector_selects <= '0;
      busy_seen <= 1'b0;
    end else if (clk_en) begin
      busy_seen <= !bus.busy_indicator_pin;
      bus.addr <= ao;
      bus.wdata <= req_data[idx_r[2:0]];
      bus.primary_sector_selects <= (act_r && !req_secondary)
        ? 8'(8'h01 << req_sector) : 8'h00;
      bus.secondary_sector_selects <= (act_r && req_secondary)
        ? 4'(4'h1 << req_sector[1:0]) : 4'h0;
      bus.write_strobe_pin_n <= !(act_r && !rd_cyc && ph_r == 2'd1);
      bus.rd_n <= !(act_r && rd_cyc && (ph_r != 2'd0 || rx_r));
    end
  end
endmodule : fcsd_host
`default_nettype wire

// ==== fcsd_monitor.sv ====
// Checker of the flash bus between the host and decoder ends.
`timescale 1ns/1ns
`default_nettype none
module fcsd_monitor #(
  parameter int OP_CYC = 64
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // Flash bus.
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic write_strobe_pin_n,
  input wire logic rd_n,
  input wire logic [7:0] primary_sector_selects,
  input wire logic [3:0] secondary_sector_selects,
  input wire logic busy_indicator_pin
);
  default clocking mon_cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [7:0] age_r;
  logic [7:0] age_nxt;
  logic [15:0] low_r;
  logic [15:0] low_nxt;
  logic busy_d_r;
  logic susp_r;
  logic susp_nxt;
  // A suspended erase lifts busy early; its low time carries over to the
  // resumed part, so only the final rise is held against the full length.
  assign susp_nxt = (!write_strobe_pin_n && !busy_indicator_pin
    && wdata == fcsd_pkg::CMD_SUSPEND) ? 1'b1 :
    (!busy_indicator_pin && busy_d_r) ? 1'b0 : susp_r;
  // Counts saturate so a long idle spell cannot wrap into a false pass.
  assign age_nxt = !write_strobe_pin_n ? 8'h00 :
    age_r + {7'h00, age_r != 8'hFF};
  assign low_nxt = (!busy_indicator_pin && busy_d_r && !susp_r) ? 16'h0001 :
    low_r + {15'h0000, !busy_indicator_pin && low_r != 16'hFFFF};
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      age_r <= 8'hFF;
      low_r <= 16'h0000;
      busy_d_r <= 1'b1;
      susp_r <= 1'b0;
    end else begin
      age_r <= age_nxt;
      low_r <= low_nxt;
      busy_d_r <= busy_indicator_pin;
      susp_r <= susp_nxt;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  strobe_pulse_a: assert property (
    $fell(write_strobe_pin_n) |=> write_strobe_pin_n)
    else $error("write strobe low for more than one cycle");
  strobe_gap_a: assert property (
    $rose(write_strobe_pin_n) |-> write_strobe_pin_n [*3])
    else $error("write strobes too close together");
  write_select_a: assert property (
    !write_strobe_pin_n |->
      (|primary_sector_selects) || (|secondary_sector_selects))
    else $error("write without any sector select");
  addr_hold_a: assert property (
    $fell(write_strobe_pin_n) |-> $stable(addr))
    else $error("address moved at the strobe fall");
  data_hold_a: assert property (
    $rose(write_strobe_pin_n) |-> $stable(wdata) && $stable(addr))
    else $error("data moved at the strobe rise");
  rdata_hold_a: assert property (
    rd_n [*5] |=> $stable(rdata))
    else $error("read data changed with no read");
  busy_cause_a: assert property (
    $fell(busy_indicator_pin) |-> age_r < 8'd16)
    else $error("busy started without a recent write");
  busy_len_a: assert property (
    $rose(busy_indicator_pin) && !susp_r |-> low_r >= OP_CYC)
    else $error("busy shorter than the operation");
endmodule : fcsd_monitor
`default_nettype wire

// ==== flash_command_sequence_decoder_tb.sv ====
// Bench joining the host and decoder ends, driven from the host side.
`timescale 1ns/1ns
`default_nettype none
module flash_command_sequence_decoder_tb;
  import fcsd_pkg::*;
  localparam logic [23:0] U1 = 24'h0555AA;
  localparam logic [23:0] U2 = 24'h0AAA55;
  localparam logic [23:0] Z = 24'h000000;
  // Identifier value is arbitrary.
  localparam logic [7:0] IDENT = 8'hC3;
  logic err;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_ready;
  logic [3:0] req_len = 4'h1;
  logic req_rd_last = 1'b0;
  logic req_secondary = 1'b0;
  logic [2:0] req_sector = 3'h0;
  logic [7:0] dq [0:6] = '{default: 8'h00};
  logic [15:0] aq [0:6] = '{default: 16'h0000};
  logic [7:0] rsp_data;
  logic rsp_valid;
  logic exec_valid;
  logic [1:0] exec_cmd;
  logic exec_secondary;
  logic [15:0] exec_addr;
  logic [7:0] exec_data;
  logic [11:0] exec_sectors;
  logic [7:0] got;
  logic [38:0] last_x;
  int num_errors = 0;
  int comparisons = 0;
  int n_exec = 0;
  fcsd_bus_if bus ();
  fcsd_device #(.TIMEOUT_CYC(50), .IDENT_CODE(IDENT)) fcsd_device_i (
    .mclk(mclk), .sys_rst(sys_rst),
    .clk_en(1'b1), .bus(bus), .array_rdata(8'h3C), .prim_protect(8'h04),
    .sec_protect(4'h0), .exec_valid(exec_valid), .exec_cmd(exec_cmd),
    .exec_secondary(exec_secondary), .exec_addr(exec_addr),
    .exec_data(exec_data), .exec_sectors(exec_sectors),
    .error_status_bit(err));
  fcsd_host fcsd_host_i (.mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1),
    .req_valid(req_valid), .req_ready(req_ready), .req_len(req_len),
    .req_data(dq), .req_addr(aq), .req_rd_last(req_rd_last),
    .req_secondary(req_secondary), .req_sector(req_sector),
    .rsp_data(rsp_data), .rsp_valid(rsp_valid), .busy_seen(), .bus(bus));
  fcsd_monitor fcsd_monitor_i (.mclk(mclk), .sys_rst(sys_rst),
    .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata),
    .write_strobe_pin_n(bus.write_strobe_pin_n), .rd_n(bus.rd_n),
    .primary_sector_selects(bus.primary_sector_selects),
    .secondary_sector_selects(bus.secondary_sector_selects),
    .busy_indicator_pin(bus.busy_indicator_pin));
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    if (exec_valid === 1'b1) begin
      n_exec++;
      last_x = {exec_sectors, exec_secondary, exec_cmd, exec_data, exec_addr};
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [15:0] exp,
      input logic [15:0] seen);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task conclude;
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  task stop(input string what);
    num_errors++;
    $display("mismatch %s expected done seen timeout", what);
    conclude();
  endtask : stop
  // Each word is address then byte; s is the array bit and sector.
  task run(input logic [3:0] n, input logic rd, input logic [3:0] s,
      input logic [23:0] w [0:6]);
    int k;
    k = 0;
    while (req_ready !== 1'b1 && k < 400) begin
      @(negedge mclk);
      k++;
    end
    for (int i = 0; i < 7; i++) begin
      aq[i] = w[i][23:8];
      dq[i] = w[i][7:0];
    end
    got = 'x;
    req_len = n;
    req_rd_last = rd;
    req_secondary = s[3];
    req_sector = s[2:0];
    req_valid = 1'b1;
    @(negedge mclk);
    req_valid = 1'b0;
    do begin
      @(negedge mclk);
      if (rsp_valid === 1'b1) got = rsp_data;
      k++;
    end while (req_ready !== 1'b1 && k < 400);
    if (k >= 400) stop("request");
  endtask : run
  task expx(input logic [1:0] c, input logic [15:0] a, input logic [7:0] d,
      input int n0);
    int k;
    k = 0;
    repeat (8) @(negedge mclk);
    chk("busy", 16'h0000, {15'h0000, bus.busy_indicator_pin});
    while (bus.busy_indicator_pin !== 1'b1 && k < 400) begin
      @(negedge mclk);
      k++;
    end
    if (k >= 400) stop("ready");
    chk("execs", n0[15:0] + 16'h0001, n_exec[15:0]);
    chk("cmd", {14'h0000, c}, {14'h0000, last_x[25:24]});
    chk("addr", a, last_x[15:0]);
    if (c == FCSD_CMD_PROG) begin
      chk("data", {8'h00, d}, {8'h00, last_x[23:16]});
    end
  endtask : expx
  // A dropped sequence must leave the device idle with nothing executed.
  task nochg(input int n0);
    repeat (30) @(negedge mclk);
    chk("busy", 16'h0001, {15'h0000, bus.busy_indicator_pin});
    chk("execs", n0[15:0], n_exec[15:0]);
  endtask : nochg
  //////////////////////////////////////////////////////////////////////////
  task t_read_prog;
    run(4'h1, 1'b1, 4'h0, '{24'h010000, Z, Z, Z, Z, Z, Z});
    chk("read", 16'h003C, {8'h00, got});
    run(4'h4, 1'b0, 4'h0, '{24'hF555AA, 24'h3AAA55, 24'h7555A0, 24'h01235A,
      Z, Z, Z});
    expx(FCSD_CMD_PROG, 16'h0123, 8'h5A, n_exec);
    run(4'h4, 1'b0, 4'hA, '{U1, U2, 24'h0555A0, 24'h004211, Z, Z, Z});
    expx(FCSD_CMD_PROG, 16'h0042, 8'h11, n_exec);
    chk("sectors", 16'h0400, {4'h0, last_x[38:27]});
    chk("array", 16'h0001, {15'h0000, last_x[26]});
  endtask : t_read_prog
  task t_query;
    run(4'h4, 1'b1, 4'h0, '{U1, U2, 24'h055590, 24'h000100, Z, Z, Z});
    chk("ident", {8'h00, IDENT}, {8'h00, got});
    run(4'h1, 1'b1, 4'h2, '{24'h000200, Z, Z, Z, Z, Z, Z});
    chk("protect", 16'h0001, {8'h00, got});
    run(4'h1, 1'b0, 4'h2, '{24'h0000F0, Z, Z, Z, Z, Z, Z});
    run(4'h1, 1'b1, 4'h2, '{24'h000200, Z, Z, Z, Z, Z, Z});
    chk("reset", 16'h003C, {8'h00, got});
    run(4'h4, 1'b1, 4'h1, '{U1, U2, 24'h055590, 24'h000200, Z, Z, Z});
    chk("unprotect", 16'h0000, {8'h00, got});
    run(4'h1, 1'b0, 4'h1, '{24'h0000F0, Z, Z, Z, Z, Z, Z});
    run(4'h4, 1'b1, 4'h8, '{U1, U2, 24'h055590, 24'h000100, Z, Z, Z});
    chk("secondary ident", 16'h003C, {8'h00, got});
    run(4'h1, 1'b0, 4'h8, '{24'h0000F0, Z, Z, Z, Z, Z, Z});
  endtask : t_query
  task t_erase;
    run(4'h6, 1'b0, 4'h0, '{U1, U2, 24'h055580, U1, U2, 24'h055510, Z});
    expx(FCSD_CMD_BERASE, 16'h0555, 8'h10, n_exec);
    run(4'h6, 1'b0, 4'h3, '{U1, U2, 24'h055580, U1, U2, 24'h300030, Z});
    run(4'h1, 1'b0, 4'h1, '{24'h100030, Z, Z, Z, Z, Z, Z});
    run(4'h1, 1'b0, 4'h3, '{24'h0000B0, Z, Z, Z, Z, Z, Z});
    run(4'h1, 1'b1, 4'h0, '{24'h010000, Z, Z, Z, Z, Z, Z});
    chk("suspended read", 16'h003C, {8'h00, got});
    run(4'h1, 1'b0, 4'h3, '{24'h000030, Z, Z, Z, Z, Z, Z});
    expx(FCSD_CMD_SERASE, 16'h1000, 8'h30, n_exec - 1);
    chk("sectors", 16'h0002, {4'h0, last_x[38:27]});
    run(4'h1, 1'b0, 4'h0, '{24'h0000B0, Z, Z, Z, Z, Z, Z});
    run(4'h1, 1'b0, 4'h0, '{24'h000030, Z, Z, Z, Z, Z, Z});
    nochg(n_exec);
  endtask : t_erase
  task t_bypass;
    run(4'h3, 1'b0, 4'h0, '{U1, U2, 24'h055520, Z, Z, Z, Z});
    run(4'h2, 1'b0, 4'h0, '{24'h0000A0, 24'h020766, Z, Z, Z, Z, Z});
    run(4'h1, 1'b1, 4'h0, '{24'h020700, Z, Z, Z, Z, Z, Z});
    chk("polling", 16'h0080, {8'h00, got});
    expx(FCSD_CMD_PROG, 16'h0207, 8'h66, n_exec - 1);
    run(4'h2, 1'b0, 4'h0, '{24'h000090, 24'h000000, Z, Z, Z, Z, Z});
    run(4'h2, 1'b0, 4'h0, '{24'h0000A0, 24'h020866, Z, Z, Z, Z, Z});
    nochg(n_exec);
  endtask : t_bypass
  task t_faults;
    run(4'h5, 1'b0, 4'h0, '{U1, U2, 24'h055533, 24'h0555A0, 24'h030077,
      Z, Z});
    nochg(n_exec);
    run(4'h2, 1'b0, 4'h0, '{U1, U2, Z, Z, Z, Z, Z});
    // Gap well past the shortened time-out of 50 cycles.
    repeat (60) @(negedge mclk);
    run(4'h2, 1'b0, 4'h0, '{24'h0555A0, 24'h030177, Z, Z, Z, Z, Z});
    nochg(n_exec);
    run(4'h4, 1'b0, 4'h2, '{U1, U2, 24'h0555A0, 24'h020455, Z, Z, Z});
    nochg(n_exec);
    chk("error", 16'h0001, {15'h0000, err});
    run(4'h1, 1'b0, 4'h2, '{24'h0000F0, Z, Z, Z, Z, Z, Z});
    nochg(n_exec);
    chk("error", 16'h0000, {15'h0000, err});
  endtask : t_faults
  initial begin
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    t_read_prog();
    t_query();
    t_erase();
    t_bypass();
    t_faults();
    conclude();
  end
endmodule : flash_command_sequence_decoder_tb
`default_nettype wire
